// ===== include/mtb_pkg.sv
// Constants for the motor PWM time base: register map, field layout, resets, modes
package mtb_pkg;
  localparam int CNT_W = 15;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Register indices on the plain register port
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_COUNT = 4'h1;
  localparam logic [3:0] ADDR_PERIOD = 4'h2;
  localparam logic [3:0] ADDR_ACTIVE_PERIOD = 4'h3;

  // Control register field positions, and the count register direction bit
  localparam int CTL_RUN_BIT = 15;
  localparam int CTL_POST_LSB = 4;
  localparam int CTL_PRE_LSB = 2;
  localparam int CTL_MODE_LSB = 0;
  localparam int COUNT_DIR_BIT = 15;

  // Time base modes
  localparam logic [1:0] MODE_FREE = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_UPDOWN = 2'h2;
  localparam logic [1:0] MODE_DOUBLE = 2'h3;

  // Prescale select codes and the terminal values of the prescale counter
  localparam logic [1:0] PRE_DIV1 = 2'h0;
  localparam logic [1:0] PRE_DIV4 = 2'h1;
  localparam logic [1:0] PRE_DIV16 = 2'h2;
  localparam logic [1:0] PRE_DIV64 = 2'h3;
  localparam logic [5:0] PRE_LAST1 = 6'h00;
  localparam logic [5:0] PRE_LAST4 = 6'h03;
  localparam logic [5:0] PRE_LAST16 = 6'h0F;
  localparam logic [5:0] PRE_LAST64 = 6'h3F;

  // Reset values
  localparam logic [14:0] COUNT_RST = 15'h0000;
  localparam logic [14:0] PERIOD_RST = 15'h0000;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [1:0] PRE_RST = 2'h0;
  localparam logic [3:0] POST_RST = 4'h0;
  localparam logic [5:0] PRE_CNT_RST = 6'h00;
  localparam logic [15:0] RDATA_RST = 16'h0000;
endpackage : mtb_pkg

// ===== core/mtb_time_base.sv
// Motor PWM time base: prescaled 15-bit up or up/down counter, period buffer, postscaled events
//
// Notes on behaviour
// [RULE_01] 15-bit counter, clock through a prescaler, match output through a postscaler.
// [RULE_02] Count register bit 15 is read-only direction: 0 up, 1 down.
// [RULE_03] Run bit starts and stops counting; stopping keeps the count value.
// [RULE_04] On count equal period, next counting clock wraps to zero or reverses.
// [RULE_05] Period zero stops counting, no events; zero period never reloads while running.
// [RULE_06] Mode field: 00 free, 01 single-shot, 10 up/down, 11 up/down double update.
// [RULE_07] Free mode counts up to period, wraps to zero, repeats while running.
// [RULE_08] Free mode raises an event per wrap, divided by the postscaler.
// [RULE_09] Single-shot counts up, wraps to zero on match and clears run.
// [RULE_10] Single-shot raises one event at match, ignoring the postscaler.
// [RULE_11] Up/down modes reverse at period match and set the direction flag.
// [RULE_12] Up/down mode raises an event at zero turnaround, divided by postscaler.
// [RULE_13] Double update raises events at zero and at period match, no postscaler.
// [RULE_14] Software must not program a period of one.
// [RULE_15] Counting clock is the core clock divided by 1, 4, 16 or 64.
// [RULE_16] Prescale counter clears on count write, control write, and reset.
// [RULE_17] Postscaler of 4 bits divides events by 1 to 16.
// [RULE_18] Postscale counter clears on count write, control write, and reset.
// [RULE_19] Period is double-buffered; reload at wrap, or at zero in up/down modes.
// [RULE_20] While stopped, the period buffer copies into the active period continuously.
// [RULE_21] Prescale codes: 00 1:1, 01 1:4, 10 1:16, 11 1:64.
// [RULE_22] Postscale code n divides by n plus one.
`timescale 1ns/10ps

module mtb_time_base #(
  parameter int ADDR_W = mtb_pkg::ADDR_W
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [15:0]            reg_rdata,
  output logic [14:0]            time_base_count,
  output logic                   count_direction_flag,
  output logic                   time_base_run,
  output logic                   period_match_pulse,
  output logic                   time_base_event
);

  typedef struct packed {
    logic        run;
    logic [1:0]  mode;
    logic [1:0]  pre_sel;
    logic [3:0]  post_sel;
    logic [14:0] count;
    logic        dir;
    logic [14:0] per_buf;
    logic [14:0] per_act;
    logic [5:0]  pre_cnt;
    logic [3:0]  post_cnt;
    logic        match_q;
    logic        event_q;
    logic [15:0] rdata;
  } mtb_state_s;

  mtb_state_s state_reg;
  mtb_state_s state_next;

  function automatic logic [5:0] mtb_pre_last(input logic [1:0] sel); // RULE_21
    case (sel)
      mtb_pkg::PRE_DIV1:  mtb_pre_last = mtb_pkg::PRE_LAST1;
      mtb_pkg::PRE_DIV4:  mtb_pre_last = mtb_pkg::PRE_LAST4;
      mtb_pkg::PRE_DIV16: mtb_pre_last = mtb_pkg::PRE_LAST16;
      mtb_pkg::PRE_DIV64: mtb_pre_last = mtb_pkg::PRE_LAST64;
      default:            mtb_pre_last = mtb_pkg::PRE_LAST1;
    endcase
  endfunction : mtb_pre_last

  logic wr_ctl;
  logic wr_cnt;
  logic wr_per;
  logic tick;
  logic advance;
  logic match;
  logic at_zero;
  logic raw_post_ev;
  logic direct_ev;

  assign wr_ctl = reg_wr && (reg_addr == mtb_pkg::ADDR_CONTROL);
  assign wr_cnt = reg_wr && (reg_addr == mtb_pkg::ADDR_COUNT);
  assign wr_per = reg_wr && (reg_addr == mtb_pkg::ADDR_PERIOD);
  // Prescale phase freezes with the run bit; a restart needs a control write, which clears it, so counting resumes on a fresh phase
  assign tick = state_reg.run && (state_reg.pre_cnt == mtb_pre_last(state_reg.pre_sel)); // RULE_15
  // Zero period parks the counter: no movement, no events
  assign advance = tick && (state_reg.per_act != 15'h0000); // RULE_05
  assign match = (state_reg.count == state_reg.per_act); // RULE_04
  assign at_zero = (state_reg.count == 15'h0000);

  always_comb begin
    state_next = state_reg;
    state_next.match_q = 1'b0;
    state_next.event_q = 1'b0;
    raw_post_ev = 1'b0;
    direct_ev = 1'b0;

    // Prescaler
    if (state_reg.run) begin
      if (tick) begin
        state_next.pre_cnt = mtb_pkg::PRE_CNT_RST;
      end else begin
        state_next.pre_cnt = state_reg.pre_cnt + 6'h01; // RULE_15
      end
    end

    if (advance) begin
      case (state_reg.mode) // RULE_06
        mtb_pkg::MODE_FREE: begin
          if (match) begin
            state_next.count = mtb_pkg::COUNT_RST; // RULE_07
            state_next.match_q = 1'b1;
            state_next.per_act = state_reg.per_buf; // RULE_19
            raw_post_ev = 1'b1; // RULE_08
          end else begin
            state_next.count = state_reg.count + 15'h0001;
          end
        end
        mtb_pkg::MODE_SINGLE: begin
          if (match) begin
            state_next.count = mtb_pkg::COUNT_RST;
            state_next.run = 1'b0; // RULE_09
            state_next.match_q = 1'b1;
            state_next.per_act = state_reg.per_buf; // RULE_19
            direct_ev = 1'b1; // RULE_10
          end else begin
            state_next.count = state_reg.count + 15'h0001;
          end
        end
        mtb_pkg::MODE_UPDOWN, mtb_pkg::MODE_DOUBLE: begin
          if (at_zero) begin
            state_next.per_act = state_reg.per_buf; // RULE_19
          end
          if (!state_reg.dir) begin
            if (match) begin
              state_next.dir = 1'b1; // RULE_11
              state_next.count = state_reg.count - 15'h0001;
              state_next.match_q = 1'b1;
              direct_ev = (state_reg.mode == mtb_pkg::MODE_DOUBLE); // RULE_13
            end else begin
              state_next.count = state_reg.count + 15'h0001;
            end
          end else if (at_zero) begin
            // Turnaround at zero: count resumes upward
            state_next.dir = 1'b0;
            state_next.count = 15'h0001;
            if (state_reg.mode == mtb_pkg::MODE_DOUBLE) begin
              direct_ev = 1'b1; // RULE_13
            end else begin
              raw_post_ev = 1'b1; // RULE_12
            end
          end else begin
            state_next.count = state_reg.count - 15'h0001;
          end
        end
        default: begin
          state_next.count = state_reg.count;
        end
      endcase
    end

    // Postscaler: code n lets every (n+1)-th event through
    if (raw_post_ev) begin
      if (state_reg.post_cnt == state_reg.post_sel) begin // RULE_22
        state_next.post_cnt = 4'h0;
        state_next.event_q = 1'b1; // RULE_17
      end else begin
        state_next.post_cnt = state_reg.post_cnt + 4'h1;
      end
    end
    if (direct_ev) begin
      state_next.event_q = 1'b1;
    end

    // Stopped: buffer flows straight into the active period
    if (!state_next.run) begin
      state_next.per_act = state_reg.per_buf; // RULE_20
    end

    // Register writes; a software control write overrides a same-cycle hardware run clear
    if (wr_ctl) begin
      state_next.run = reg_wdata[mtb_pkg::CTL_RUN_BIT]; // RULE_03
      state_next.mode = reg_wdata[mtb_pkg::CTL_MODE_LSB +: 2];
      state_next.pre_sel = reg_wdata[mtb_pkg::CTL_PRE_LSB +: 2];
      state_next.post_sel = reg_wdata[mtb_pkg::CTL_POST_LSB +: 4];
    end
    // Leaving up/down mid-slope must not leave the flag reading downward
    if (!state_next.mode[1]) begin
      state_next.dir = 1'b0; // RULE_02
    end
    if (wr_cnt) begin
      state_next.count = reg_wdata[14:0];
    end
    if (wr_ctl || wr_cnt) begin
      state_next.pre_cnt = mtb_pkg::PRE_CNT_RST; // RULE_16
      state_next.post_cnt = 4'h0; // RULE_18
    end
    if (wr_per) begin
      state_next.per_buf = reg_wdata[14:0];
    end

    // Read data stands only in the cycle after the read strobe
    state_next.rdata = mtb_pkg::RDATA_RST;
    if (reg_rd) begin
      case (reg_addr)
        mtb_pkg::ADDR_CONTROL: begin
          state_next.rdata[mtb_pkg::CTL_RUN_BIT] = state_reg.run;
          state_next.rdata[mtb_pkg::CTL_MODE_LSB +: 2] = state_reg.mode;
          state_next.rdata[mtb_pkg::CTL_PRE_LSB +: 2] = state_reg.pre_sel;
          state_next.rdata[mtb_pkg::CTL_POST_LSB +: 4] = state_reg.post_sel;
        end
        mtb_pkg::ADDR_COUNT: begin
          state_next.rdata = {state_reg.dir, state_reg.count}; // RULE_02
        end
        mtb_pkg::ADDR_PERIOD: begin
          state_next.rdata = {1'b0, state_reg.per_buf};
        end
        mtb_pkg::ADDR_ACTIVE_PERIOD: begin
          state_next.rdata = {1'b0, state_reg.per_act};
        end
        default: begin
          state_next.rdata = mtb_pkg::RDATA_RST;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg.run <= 1'b0;
      state_reg.mode <= mtb_pkg::MODE_RST;
      state_reg.pre_sel <= mtb_pkg::PRE_RST;
      state_reg.post_sel <= mtb_pkg::POST_RST;
      state_reg.count <= mtb_pkg::COUNT_RST;
      state_reg.dir <= 1'b0;
      state_reg.per_buf <= mtb_pkg::PERIOD_RST;
      state_reg.per_act <= mtb_pkg::PERIOD_RST;
      state_reg.pre_cnt <= mtb_pkg::PRE_CNT_RST; // RULE_16
      state_reg.post_cnt <= 4'h0; // RULE_18
      state_reg.match_q <= 1'b0;
      state_reg.event_q <= 1'b0;
      state_reg.rdata <= mtb_pkg::RDATA_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata = state_reg.rdata;
  assign time_base_count = state_reg.count; // RULE_01
  assign count_direction_flag = state_reg.dir;
  assign time_base_run = state_reg.run;
  assign period_match_pulse = state_reg.match_q;
  assign time_base_event = state_reg.event_q;

  // Checks
  AST_DIR_READBACK: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
    (reg_rd && reg_addr == mtb_pkg::ADDR_COUNT) |=> (reg_rdata[15] == $past(state_reg.dir)))
    else $error("Direction flag not returned in count read");

  AST_STOP_HOLDS: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
    (!state_reg.run && !wr_cnt) |=> $stable(time_base_count))
    else $error("Count moved while stopped");

  AST_FREE_WRAP: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
    (advance && state_reg.mode == mtb_pkg::MODE_FREE && match && !wr_cnt)
      |=> (time_base_count == 15'h0000) && period_match_pulse)
    else $error("Free mode did not wrap at period");

  AST_SINGLE_STOP: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
    (advance && state_reg.mode == mtb_pkg::MODE_SINGLE && match && !reg_wr)
      |=> !time_base_run && time_base_event ##1 !time_base_event)
    else $error("Single shot did not stop with one event");

  AST_UD_REVERSE: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
    (advance && state_reg.mode[1] && !state_reg.dir && match && !wr_cnt)
      |=> count_direction_flag && (time_base_count == $past(state_reg.count) - 15'h0001))
    else $error("Up/down did not reverse at period");

  AST_ZERO_PERIOD: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
    (state_reg.per_act == 15'h0000 && !reg_wr) |=> !time_base_event && $stable(time_base_count))
    else $error("Zero period still active");

  AST_SCALER_CLEAR: assert property (@(posedge clk) disable iff (!rst_n) // RULE_16
    (wr_ctl || wr_cnt) |=> (state_reg.pre_cnt == 6'h00) && (state_reg.post_cnt == 4'h0)) // RULE_18
    else $error("Scaler counters not cleared by write");

  AST_IDLE_LOAD: assert property (@(posedge clk) disable iff (!rst_n) // RULE_20
    (!state_reg.run && !wr_ctl) |=> (state_reg.per_act == $past(state_reg.per_buf)))
    else $error("Period buffer not copied while stopped");

  AST_PRESCALE_64: assert property (@(posedge clk) disable iff (!rst_n) // RULE_15
    (tick && state_reg.pre_sel == mtb_pkg::PRE_DIV64)
      |-> $past(state_reg.run, 63) && ($past(state_reg.pre_cnt) == 6'h3E))
    else $error("Prescale 1:64 ticked early");

  AST_DOUBLE_EVENTS: assert property (@(posedge clk) disable iff (!rst_n) // RULE_13
    (advance && state_reg.mode == mtb_pkg::MODE_DOUBLE && match && !state_reg.dir) |=> time_base_event)
    else $error("Double update missed match event");

  // Mode, flag and event relations seen from the outputs
  AST_UP_ONLY_DIR: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
    !state_reg.mode[1] |-> !count_direction_flag)
    else $error("Direction flag set in an up-only mode");

  AST_RUN_START: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
    (wr_ctl && reg_wdata[mtb_pkg::CTL_RUN_BIT]) |=> time_base_run)
    else $error("Run bit write did not start the time base");

  AST_STOPPED_QUIET: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
    !state_reg.run |=> !time_base_event && !period_match_pulse)
    else $error("Event or match while stopped");

  AST_MATCH_FROM_TICK: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
    period_match_pulse |-> $past(advance && match))
    else $error("Match pulse without a counting tick at period");

  AST_FREE_COUNT_UP: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
    (advance && state_reg.mode == mtb_pkg::MODE_FREE && !match && !wr_cnt)
      |=> (time_base_count == $past(state_reg.count) + 15'h0001))
    else $error("Free mode did not count up");

  AST_SINGLE_EVENT: assert property (@(posedge clk) disable iff (!rst_n) // RULE_10
    (advance && state_reg.mode == mtb_pkg::MODE_SINGLE && match) |=> time_base_event)
    else $error("Single shot event held back");

  AST_CTL_KEEPS_COUNT: assert property (@(posedge clk) disable iff (!rst_n) // RULE_16
    (wr_ctl && !advance) |=> $stable(time_base_count))
    else $error("Control write disturbed the count");

  AST_POST_HOLDS_BACK: assert property (@(posedge clk) disable iff (!rst_n) // RULE_17
    (raw_post_ev && state_reg.post_cnt != state_reg.post_sel) |=> !time_base_event)
    else $error("Postscaler let an early event through");

  AST_UD_TURN_UP: assert property (@(posedge clk) disable iff (!rst_n) // RULE_12
    (advance && state_reg.mode[1] && state_reg.dir && at_zero && !wr_cnt)
      |=> !count_direction_flag && (time_base_count == 15'h0001))
    else $error("Up/down did not resume upward at zero");

  AST_UD_ZERO_EVENT: assert property (@(posedge clk) disable iff (!rst_n) // RULE_12
    (advance && state_reg.mode == mtb_pkg::MODE_UPDOWN && state_reg.dir && at_zero
      && state_reg.post_cnt == state_reg.post_sel) |=> time_base_event)
    else $error("Up/down missed the zero event");

  AST_DOUBLE_ZERO: assert property (@(posedge clk) disable iff (!rst_n) // RULE_13
    (advance && state_reg.mode == mtb_pkg::MODE_DOUBLE && state_reg.dir && at_zero) |=> time_base_event)
    else $error("Double update missed zero event");

  // Period buffer transfer points
  AST_UD_RELOAD: assert property (@(posedge clk) disable iff (!rst_n) // RULE_19
    (advance && state_reg.mode[1] && at_zero) |=> (state_reg.per_act == $past(state_reg.per_buf)))
    else $error("Up/down period not reloaded at zero");

  AST_FREE_KEEPS_PERIOD: assert property (@(posedge clk) disable iff (!rst_n) // RULE_19
    (state_reg.run && state_reg.mode == mtb_pkg::MODE_FREE && !(advance && match) && !wr_ctl)
      |=> $stable(state_reg.per_act))
    else $error("Active period changed before the wrap");

  AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
    !reg_rd |=> (reg_rdata == 16'h0000))
    else $error("Read data stood outside its cycle");

  COV_FREE_WRAP: cover property (@(posedge clk) disable iff (!rst_n)
    advance && state_reg.mode == mtb_pkg::MODE_FREE && match);
  COV_SINGLE_DONE: cover property (@(posedge clk) disable iff (!rst_n)
    $fell(time_base_run) && time_base_event);
  COV_UD_TURN: cover property (@(posedge clk) disable iff (!rst_n)
    $fell(count_direction_flag) && state_reg.mode == mtb_pkg::MODE_UPDOWN);
  COV_POSTSCALE: cover property (@(posedge clk) disable iff (!rst_n)
    time_base_event && state_reg.post_sel == 4'hF);
  COV_DOUBLE_MATCH: cover property (@(posedge clk) disable iff (!rst_n)
    time_base_event && period_match_pulse && state_reg.mode == mtb_pkg::MODE_DOUBLE);

endmodule : mtb_time_base

// ===== dv/tb.sv
// Self-checking testbench for the motor PWM time base
`timescale 1ns/10ps

module tb;
  localparam logic [3:0] A_CTL = mtb_pkg::ADDR_CONTROL;
  localparam logic [3:0] A_CNT = mtb_pkg::ADDR_COUNT;
  localparam logic [3:0] A_PER = mtb_pkg::ADDR_PERIOD;
  localparam logic [3:0] A_ACT = mtb_pkg::ADDR_ACTIVE_PERIOD;

  logic        clk;
  logic        rst_n;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [14:0] time_base_count;
  logic        count_direction_flag;
  logic        time_base_run;
  logic        period_match_pulse;
  logic        time_base_event;
  int          num_errors = 0;
  int          checked = 0;

  mtb_time_base uut (
    .clk                  (clk),
    .rst_n                (rst_n),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_rdata            (reg_rdata),
    .time_base_count      (time_base_count),
    .count_direction_flag (count_direction_flag),
    .time_base_run        (time_base_run),
    .period_match_pulse   (period_match_pulse),
    .time_base_event      (time_base_event)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // Data is taken just after the edge that accepted the strobe, its only valid cycle
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic regs_test;
    logic [15:0] d;
    for (int a = 0; a < 4; a++) begin
      rd(4'(a), d);
      chk(d, 16'h0000, "reset value");
    end
    wr(4'h9, 16'hFFFF);
    rd(4'h9, d);
    chk(d, 16'h0000, "unmapped read");
    @(posedge clk);
    #1;
    chk(reg_rdata, 16'h0000, "read data after its cycle");
    wr(A_CTL, 16'h00F5);
    rd(A_CTL, d);
    chk(d, 16'h00F5, "control readback");
    wr(A_PER, 16'hFFFF);
    rd(A_PER, d);
    chk(d, 16'h7FFF, "period buffer width");
    wr(A_PER, 16'h0007);
    rd(A_ACT, d);
    chk(d, 16'h0007, "active copies buffer while stopped");
    wr(A_CTL, 16'h0000);
    $display("regs_test done");
  endtask : regs_test

  task automatic free_run(input logic [1:0] pre, input logic [3:0] post);
    int          div;
    int          per;
    logic [15:0] d;
    logic [15:0] d2;
    div = 1 << (2 * pre);
    per = 3 * div;
    wr(A_PER, 16'h0002);
    wr(A_CNT, 16'h0000);
    wr(A_CTL, {1'b1, 7'h00, post, pre, mtb_pkg::MODE_FREE});
    for (int i = 0; i <= 2 * per * (int'(post) + 1); i++) begin
      if (i > 0) @(posedge clk);
      #1;
      chk({1'b0, time_base_count}, 16'((i / div) % 3), "free count");
      chk(16'(period_match_pulse), 16'(i % per == 0 && i > 0), "free match");
      chk(16'(time_base_event), 16'(i % (per * (int'(post) + 1)) == 0 && i > 0), "free event");
    end
    wr(A_CTL, 16'h0000);
    rd(A_CNT, d);
    repeat (4) @(posedge clk);
    rd(A_CNT, d2);
    chk(d2, d, "count held after stop");
    chk(16'(time_base_run), 16'h0000, "run cleared");
    $display("free_run pre %0d post %0d done", pre, post);
  endtask : free_run

  task automatic single_shot;
    wr(A_PER, 16'h0003);
    wr(A_CNT, 16'h0000);
    wr(A_CTL, {1'b1, 7'h00, 4'h3, mtb_pkg::PRE_DIV1, mtb_pkg::MODE_SINGLE});
    for (int i = 0; i <= 10; i++) begin
      if (i > 0) @(posedge clk);
      #1;
      chk({1'b0, time_base_count}, 16'(i <= 3 ? i : 0), "single count");
      chk(16'(time_base_run), 16'(i <= 3), "single run");
      chk(16'(time_base_event), 16'(i == 4), "single event");
    end
    $display("single_shot done");
  endtask : single_shot

  task automatic zero_period;
    logic [15:0] d;
    wr(A_PER, 16'h0000);
    wr(A_CNT, 16'h8005);
    rd(A_CNT, d);
    chk(d, 16'h0005, "direction bit read-only");
    wr(A_CTL, 16'h8000);
    repeat (8) begin
      @(posedge clk);
      #1;
      chk({1'b0, time_base_count}, 16'h0005, "zero period count");
      chk(16'(time_base_event), 16'h0000, "zero period event");
    end
    wr(A_CTL, 16'h0000);
    $display("zero_period done");
  endtask : zero_period

  // Slow prescale keeps the wrap far from the buffer write and the read
  task automatic buffer_test;
    logic [15:0] d;
    int          n;
    wr(A_PER, 16'h0002);
    wr(A_CNT, 16'h0000);
    wr(A_CTL, {1'b1, 7'h00, 4'h0, mtb_pkg::PRE_DIV64, mtb_pkg::MODE_FREE});
    wr(A_PER, 16'h0005);
    rd(A_ACT, d);
    chk(d, 16'h0002, "active kept while running");
    n = 0;
    while (period_match_pulse !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({1'b0, time_base_count}, 16'h0000, "wrap on old period");
    rd(A_ACT, d);
    chk(d, 16'h0005, "active loaded at wrap");
    n = 0;
    while (time_base_count !== 15'h0005 && n < 500) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({1'b0, time_base_count}, 16'h0005, "new period reached");
    wr(A_CTL, 16'h0000);
    $display("buffer_test done");
  endtask : buffer_test

  task automatic updown(input logic [1:0] mode, input logic [3:0] post);
    int   k;
    logic ev;
    wr(A_PER, 16'h0003);
    wr(A_CNT, 16'h0000);
    wr(A_CTL, {1'b1, 7'h00, post, mtb_pkg::PRE_DIV1, mode});
    for (int i = 0; i <= 28; i++) begin
      if (i > 0) @(posedge clk);
      #1;
      k = i % 6;
      chk({1'b0, time_base_count}, 16'(k <= 3 ? k : 6 - k), "updown count");
      chk(16'(count_direction_flag), 16'(k >= 4 || (k == 0 && i > 0)), "direction");
      chk(16'(period_match_pulse), 16'(k == 4), "updown match");
      if (mode == mtb_pkg::MODE_DOUBLE)
        ev = (k == 4) || (k == 1 && i > 1);
      else
        ev = k == 1 && i > 1 && ((i - 1) / 6) % (int'(post) + 1) == 0;
      chk(16'(time_base_event), 16'(ev), "updown event");
    end
    // Stop while counting down: the up-only mode that the write selects must clear the flag
    wr(A_CTL, 16'h0000);
    #1;
    chk(16'(count_direction_flag), 16'h0000, "direction cleared in up-only mode");
    $display("updown mode %0d done", mode);
  endtask : updown

  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  initial begin
    #50000;
    num_errors++;
    $display("BAD t=%0t watchdog expired", $time);
    summarize();
  end

  initial begin
    rst_n     = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    regs_test();
    free_run(mtb_pkg::PRE_DIV1, 4'h0);
    free_run(mtb_pkg::PRE_DIV4, 4'h1);
    free_run(mtb_pkg::PRE_DIV16, 4'h0);
    free_run(mtb_pkg::PRE_DIV64, 4'h0);
    free_run(mtb_pkg::PRE_DIV1, 4'hF);
    single_shot();
    zero_period();
    buffer_test();
    updown(mtb_pkg::MODE_UPDOWN, 4'h1);
    updown(mtb_pkg::MODE_DOUBLE, 4'h1);
    summarize();
  end
endmodule : tb
